// [hw/adc_regs_pkg.sv]
package adc_regs_pkg;
   localparam int WORD_BITS = 16;
   localparam int DATA_BITS = 14;
   localparam int RESULT_BITS = 12;
   localparam int LEAD_ZEROS = 4;
   localparam int CNT_BITS = 5;
   localparam logic [4:0] LAST_BIT = 5'h10;
   // write address field, bits 15:14 of the word
   localparam int ADDR_HI_POS = 15;
   localparam int ADDR_LO_POS = 14;
   localparam logic [1:0] WADDR_NONE = 2'h0;
   localparam logic [1:0] WADDR_TEST = 2'h1;
   localparam logic [1:0] WADDR_CAL = 2'h2;
   localparam logic [1:0] WADDR_CTRL = 2'h3;
   // read-select field inside the control register
   localparam int RDSEL_LO_POS = 6;
   localparam int RDSEL_HI_POS = 7;
   localparam logic [1:0] RDSEL_RESULT = 2'h0;
   localparam logic [1:0] RDSEL_TEST = 2'h1;
   localparam logic [1:0] RDSEL_CAL = 2'h2;
   localparam logic [1:0] RDSEL_STATUS = 2'h3;
   localparam logic [13:0] CTRL_RESET = 14'h0000;
   localparam logic [13:0] TEST_RESET = 14'h0000;
   localparam logic [13:0] CAL_RESET = 14'h0000;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage : adc_regs_pkg

// [hw/link_sampler.sv]
`timescale 1ns/1ps
// two-flop synchroniser for the host pins plus serial clock edge finding
module link_sampler
   import adc_regs_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic sys_rst,
   // raw pins
   input wire logic serClk,
   input wire logic frameSyncN,
   input wire logic serIn,
   // synchronised
   output logic frameActive,
   output logic clkRise,
   output logic clkFall,
   output logic dataIn
);
   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic clkPrev_r;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         // idle pin levels: clock low, sync high, data low, so no
         // false serial clock edge follows the release of reset
         meta_r <= 3'h2;
         sync_r <= 3'h2;
         clkPrev_r <= 1'b0;
      end else begin
         meta_r <= {serClk, frameSyncN, serIn};
         sync_r <= meta_r;
         clkPrev_r <= sync_r[2];
      end
   end

   assign frameActive = ~sync_r[1];
   assign clkRise = sync_r[2] & ~clkPrev_r;
   assign clkFall = ~sync_r[2] & clkPrev_r;
   assign dataIn = sync_r[0];
endmodule : link_sampler

// [hw/adc_serial_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - each write word is 16 bits: 2 address bits, 14 data bits.
// - nothing is updated until all 16 bits have arrived.
// - address 0 discards, 1 test, 2 calibration, 3 control register.
// - read-select 0 result, 1 test, 2 calibration, 3 status.
// - read-select is zero after power-up, so reads return results.
// - read-select stays in force until rewritten.
// - result reads carry four leading zeros before the 12-bit value.
// - control write-only, result and status read-only, others read/write.
// - defaults after power-up need no write beyond channel choice.
// - all 14 control bits clear at power-up.
// - active-low frame sync frames the host serial clock.
// - read data leaves on the serial output as a 16-bit word.
module adc_serial_regs
   import adc_regs_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic sys_rst,
   // serial link pins
   input wire logic serClk,
   input wire logic frameSyncN,
   input wire logic serIn,
   output logic serOut,
   // converter core side
   input wire logic [11:0] convResult,
   input wire logic [15:0] devStatus,
   output logic [13:0] controlWord,
   output logic [13:0] testWord,
   output logic [13:0] calWord,
   output logic calWriteStb,
   output logic [1:0] readSelect
);
   typedef enum logic [1:0] {IDLE, SHIFT, DONE} link_state_t;

   link_state_t state_r;
   logic frameActive;
   logic clkRise;
   logic clkFall;
   logic dataIn;
   logic [15:0] shiftIn_r;
   logic [15:0] shiftOut_r;
   logic [4:0] bitCnt_r;
   logic [13:0] ctrl_r;
   logic [13:0] test_r;
   logic [13:0] cal_r;
   logic calStb_r;
   logic wordDone;
   logic [1:0] wAddr;
   logic [13:0] wData;

   // pick the read word for the current selection
   function automatic logic [15:0] readWord(input logic [1:0] sel,
                                            input logic [11:0] res,
                                            input logic [13:0] tst,
                                            input logic [13:0] cal,
                                            input logic [15:0] sts);
      logic [15:0] w;
      w = WORD_ZERO;
      case (sel)
         RDSEL_RESULT: w = {{LEAD_ZEROS{1'b0}}, res};
         RDSEL_TEST: w = {2'b00, tst};
         RDSEL_CAL: w = {2'b00, cal};
         RDSEL_STATUS: w = sts;
         default: w = WORD_ZERO;
      endcase
      return w;
   endfunction : readWord

   link_sampler u_sampler (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .serClk(serClk),
      .frameSyncN(frameSyncN),
      .serIn(serIn),
      .frameActive(frameActive),
      .clkRise(clkRise),
      .clkFall(clkFall),
      .dataIn(dataIn)
   );

   // frame state: a frame is framed by sync low
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= IDLE;
      end else begin
         case (state_r)
            IDLE: begin
               if (frameActive) begin
                  state_r <= SHIFT;
               end
            end
            SHIFT: begin
               if (!frameActive) begin
                  state_r <= IDLE;
               end else if (wordDone) begin
                  state_r <= DONE;
               end
            end
            DONE: begin
               // extra clocks after bit 16 are ignored until sync rises
               if (!frameActive) begin
                  state_r <= IDLE;
               end
            end
            default: state_r <= IDLE;
         endcase
      end
   end

   // receive shifter, msb first, sampled on serial clock rise
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         shiftIn_r <= WORD_ZERO;
         bitCnt_r <= 5'h00;
      end else if (state_r == IDLE) begin
         shiftIn_r <= WORD_ZERO;
         bitCnt_r <= 5'h00;
      end else if (state_r == SHIFT && frameActive && clkRise) begin
         shiftIn_r <= {shiftIn_r[14:0], dataIn};
         bitCnt_r <= bitCnt_r + 5'h01;
      end
   end

   assign wordDone = (state_r == SHIFT) && (bitCnt_r == LAST_BIT);
   assign wAddr = {shiftIn_r[ADDR_HI_POS], shiftIn_r[ADDR_LO_POS]};
   assign wData = shiftIn_r[DATA_BITS-1:0];

   // register writes only on a complete word
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= CTRL_RESET;
         test_r <= TEST_RESET;
         cal_r <= CAL_RESET;
         calStb_r <= 1'b0;
      end else begin
         calStb_r <= 1'b0;
         if (wordDone && frameActive) begin
            case (wAddr)
               WADDR_NONE: ; // data discarded
               WADDR_TEST: test_r <= wData;
               WADDR_CAL: begin
                  cal_r <= wData;
                  calStb_r <= 1'b1;
               end
               WADDR_CTRL: ctrl_r <= wData;
               default: ;
            endcase
         end
      end
   end

   // transmit: load at frame start, shift on falling serial clock
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         shiftOut_r <= WORD_ZERO;
      end else if (state_r == IDLE && frameActive) begin
         // control register never appears here: write-only
         shiftOut_r <= readWord(readSelect, convResult, test_r, cal_r,
                                devStatus);
      end else if (state_r == SHIFT && frameActive && clkFall) begin
         shiftOut_r <= {shiftOut_r[14:0], 1'b0};
      end
   end

   assign serOut = shiftOut_r[WORD_BITS-1];
   assign readSelect = {ctrl_r[RDSEL_HI_POS], ctrl_r[RDSEL_LO_POS]};
   assign controlWord = ctrl_r;
   assign testWord = test_r;
   assign calWord = cal_r;
   assign calWriteStb = calStb_r;
endmodule : adc_serial_regs

// [test/adc_serial_regs_chk.sv]
`timescale 1ns/1ps
module adc_serial_regs_chk
   import adc_regs_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic sys_rst,
   // link
   input wire logic serClk,
   input wire logic frameSyncN,
   input wire logic serOut,
   // registers
   input wire logic [13:0] controlWord,
   input wire logic [13:0] testWord,
   input wire logic [13:0] calWord,
   input wire logic calWriteStb,
   input wire logic [1:0] readSelect
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_sel_mirror: assert property (readSelect == controlWord[7:6])
      else $error("read select not from control bits");
   a_ctrl_hold: assert property (frameSyncN [*8] |=> $stable(controlWord))
      else $error("control changed outside a frame");
   a_test_hold: assert property (frameSyncN [*8] |=> $stable(testWord))
      else $error("test changed outside a frame");
   a_cal_hold: assert property (frameSyncN [*8] |=> $stable(calWord))
      else $error("cal changed outside a frame");
   a_stb_pulse: assert property (calWriteStb |=> !calWriteStb)
      else $error("cal strobe longer than one cycle");
   a_cal_stb: assert property ($changed(calWord) |-> ##[0:2] calWriteStb)
      else $error("cal write without strobe");
   // idle link clock inside a frame must not move the output
   a_out_hold: assert property ((!frameSyncN && $stable(serClk)
      && $stable(frameSyncN)) [*6] |=> $stable(serOut))
      else $error("serial out moved without clock");
   a_reset_clear: assert property ($fell(sys_rst) |-> controlWord == CTRL_RESET
      && readSelect == RDSEL_RESULT && !calWriteStb)
      else $error("registers not clear after reset");
   cover property (calWriteStb);
   cover property ($changed(readSelect));
   cover property ($changed(testWord));
endmodule : adc_serial_regs_chk

bind adc_serial_regs adc_serial_regs_chk chk (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .serClk(serClk), .frameSyncN(frameSyncN),
   .serOut(serOut), .controlWord(controlWord), .testWord(testWord),
   .calWord(calWord), .calWriteStb(calWriteStb), .readSelect(readSelect));

// [test/host_model.sv]
`timescale 1ns/1ps
module host_model (
   // link
   output logic serClk,
   output logic frameSyncN,
   output logic serIn,
   input wire logic serOut
);
   initial begin
      serClk = 1'b0;
      frameSyncN = 1'b1;
      serIn = 1'b0;
   end
   // n below 16 makes an aborted frame
   task automatic xfer(input logic [15:0] w, input int n,
      output logic [15:0] r);
      r = 16'h0000;
      frameSyncN = 1'b0;
      #200;
      for (int i = 15; i > 15 - n; i--) begin
         serIn = w[i];
         #100 serClk = 1'b1;
         r = {r[14:0], serOut};
         #100 serClk = 1'b0;
      end
      // clock stands still, data no longer valid
      serIn = ~serIn;
      #200 frameSyncN = 1'b1;
      #200;
   endtask : xfer
endmodule : host_model

// [test/test_adc_serial_regs.sv]
`timescale 1ns/1ps
module test_adc_serial_regs;
   import adc_regs_pkg::*;
   logic clk_sys, sys_rst, serClk, frameSyncN, serIn, serOut, calWriteStb;
   logic [11:0] convResult;
   logic [15:0] devStatus, rd;
   logic [13:0] controlWord, testWord, calWord;
   logic [1:0] readSelect;
   logic [15:0] expTab [4];
   int fails = 0;
   int n_compared = 0;
   int stbCount = 0;
   always @(posedge clk_sys) begin
      if (calWriteStb === 1'b1) stbCount++;
   end
   adc_serial_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .serClk(serClk), .frameSyncN(frameSyncN), .serIn(serIn),
      .serOut(serOut), .convResult(convResult), .devStatus(devStatus),
      .controlWord(controlWord), .testWord(testWord), .calWord(calWord),
      .calWriteStb(calWriteStb), .readSelect(readSelect));
   host_model host (.serClk(serClk), .frameSyncN(frameSyncN),
      .serIn(serIn), .serOut(serOut));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   initial begin
      #200000;
      fails++;
      final_report();
   end
   initial begin
      sys_rst = 1'b1;
      convResult = 12'h0a5c;
      devStatus = 16'hbeef;
      repeat (12) @(posedge clk_sys);
      #2 sys_rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #2 host.xfer(16'h0000, 16, rd);
      chk(rd, {4'h0, convResult});
      chk({2'b00, controlWord}, 16'h0000);
      // test register written once only, to prove the decode
      host.xfer(16'h5234, 16, rd);
      chk({2'b00, testWord}, 16'h1234);
      host.xfer(16'ha5a5, 16, rd);
      chk({2'b00, calWord}, 16'h25a5);
      host.xfer(16'h3fff, 16, rd);
      chk({2'b00, testWord}, 16'h1234);
      chk({2'b00, calWord}, 16'h25a5);
      host.xfer(16'hffff, 15, rd);
      chk({2'b00, controlWord}, 16'h0000);
      $display("write tests done");
      expTab = '{{4'h0, convResult}, 16'h1234, 16'h25a5, devStatus};
      for (int s = 0; s < 4; s++) begin
         host.xfer({2'b11, 6'h00, s[1:0], 6'h00}, 16, rd);
         chk({14'h0000, readSelect}, 16'(s));
         host.xfer(16'h0000, 16, rd);
         chk(rd, expTab[s]);
         host.xfer(16'h0000, 16, rd);
         chk(rd, expTab[s]);
      end
      chk(16'(stbCount), 16'h0001);
      $display("read select tests done");
      final_report();
   end
endmodule : test_adc_serial_regs
